// file: rtl/fpsc_ctrl.sv
// Flash command status and protection supervision with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Disallowed protection writes leave register unchanged
// - Scenarios 0..3 transitions follow fixed set
// - Scenarios 4..7 transitions follow fixed set
// - Protection register reads current scenario
// - Normal mode status bit access classes
// - Special mode exposes fail and done
// - Buffer empty clears only by writing one
// - Zero write mid-sequence aborts, sets access error
// - Buffer empty interrupt when flag and enable
// - Complete flag follows buffer and engine idle
// - Complete interrupt when flag and enable
// - Protected program/erase sets violation, write-one clears
// - Violation, access error or fail block launch
// - Sequence error, bad code, stop while complete flag low set error
// - Blank set by verify, cleared at launch
// - Special mode verify failure sets fail
// - Special mode done low while engine active
// - Size fields writable only while range disabled
// - Only four command codes are valid
module fpsc_ctrl #(
    parameter logic [7:0] PROT_RESET = `FPSC_RST_PROT
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic arrayWrite,
    input wire logic arrayWriteProt,
    input wire logic stopReq,
    input wire logic cmdTaken,
    input wire logic engineActive,
    input wire logic verifyDone,
    input wire logic verifyBlank,
    output logic cmdLaunch,
    output fpsc_pkg::fpsc_byte_t cmdCode,
    output fpsc_pkg::fpsc_byte_t protConfig,
    output logic irqBufferEmpty,
    output logic irqComplete
);
    import fpsc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state so read data comes from a flop
    logic ackd;
    logic next_ackd;
    logic access;
    logic mapped;
    logic wrEn;
    logic [2:0] idx;
    logic wrStat;
    logic wrProt;
    logic wrCfg;
    logic wrCmd;
    logic wrMode;
    fpsc_byte_t rdByte;
    logic [31:0] next_prdata;

    assign idx = paddr[4:2];
    assign access = psel && penable;
    assign mapped = (paddr[1:0] == 2'h0) && (idx == `FPSC_IDX_MODE ||
        idx == `FPSC_IDX_CONFIG || idx == `FPSC_IDX_PROT ||
        idx == `FPSC_IDX_STATUS || idx == `FPSC_IDX_CMD);
    assign pready = access && ackd;
    assign pslverr = pready && !mapped;
    assign wrEn = pready && pwrite && mapped;
    assign wrStat = wrEn && idx == `FPSC_IDX_STATUS;
    assign wrProt = wrEn && idx == `FPSC_IDX_PROT;
    assign wrCfg = wrEn && idx == `FPSC_IDX_CONFIG;
    assign wrCmd = wrEn && idx == `FPSC_IDX_CMD;
    assign wrMode = wrEn && idx == `FPSC_IDX_MODE;

    //////////////////////////////////////////////////////////////////////////
    // State
    fpsc_seq_t seq;
    fpsc_seq_t next_seq;
    logic cbef;
    logic next_cbef;
    logic ccf;
    logic next_ccf;
    logic viol;
    logic next_viol;
    logic access_error_flag;
    logic next_access_error_flag;
    logic blank;
    logic next_blank;
    logic fail;
    logic next_fail;
    logic next_launch;
    logic specialMode;
    logic next_specialMode;
    fpsc_byte_t cfgReg;
    fpsc_byte_t next_config;
    fpsc_byte_t next_cmdCode;
    fpsc_byte_t next_prot;
    fpsc_byte_t reqProt;
    fpsc_byte_t status;
    logic blocked;
    logic setAcc;
    logic setViol;
    logic validCode;

    fpsc_prot_if protChk ();

    fpsc_prot_check u_check
    (
        .chk(protChk)
    );

    assign protChk.curIdx = {protConfig[`FPSC_BIT_OPEN], protConfig[`FPSC_BIT_HDIS],
        protConfig[`FPSC_BIT_LDIS]};
    assign protChk.reqIdx = {reqProt[`FPSC_BIT_OPEN], reqProt[`FPSC_BIT_HDIS],
        reqProt[`FPSC_BIT_LDIS]};

    assign blocked = viol || access_error_flag || fail;
    assign irqBufferEmpty = cbef && cfgReg[`FPSC_BIT_BEIRQ];
    assign irqComplete = ccf && cfgReg[`FPSC_BIT_CCIRQ];

    always_comb
    begin
        validCode = 1'b0;
        case (pwdata[7:0] & `FPSC_MSK_CMD)
            `FPSC_CMD_VERIFY: validCode = 1'b1;
            `FPSC_CMD_PROGRAM: validCode = 1'b1;
            `FPSC_CMD_SECTOR: validCode = 1'b1;
            `FPSC_CMD_MASS: validCode = 1'b1;
            default: validCode = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Protection: size bits pass only while their range is disabled
    always_comb
    begin
        reqProt = pwdata[7:0];
        if (!protConfig[`FPSC_BIT_HDIS])
        begin
            reqProt = (reqProt & ~`FPSC_MSK_HSIZE) | (protConfig & `FPSC_MSK_HSIZE);
        end
        if (!protConfig[`FPSC_BIT_LDIS])
        begin
            reqProt = (reqProt & ~`FPSC_MSK_LSIZE) | (protConfig & `FPSC_MSK_LSIZE);
        end
        next_prot = protConfig;
        if (wrProt && protChk.allowed)
        begin
            next_prot = reqProt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command sequence and status flags
    always_comb
    begin
        next_seq = seq;
        next_cbef = cbef;
        next_blank = blank;
        next_launch = 1'b0;
        next_cmdCode = cmdCode;
        next_config = cfgReg;
        next_specialMode = specialMode;
        setAcc = 1'b0;
        setViol = 1'b0;
        if (wrCfg)
        begin
            next_config = pwdata[7:0] & 8'hC0;
        end
        if (wrMode)
        begin
            next_specialMode = pwdata[0];
        end
        case (seq)
            SEQ_IDLE:
            begin
                if (arrayWrite && arrayWriteProt)
                begin
                    setViol = 1'b1;
                end
                else if (arrayWrite && !blocked)
                begin
                    next_seq = SEQ_ADDR;
                end
                else if (wrCmd)
                begin
                    setAcc = 1'b1;
                end
            end
            SEQ_ADDR:
            begin
                if (arrayWrite)
                begin
                    setAcc = 1'b1;
                    next_seq = SEQ_IDLE;
                end
                else if (wrCmd && validCode)
                begin
                    next_cmdCode = pwdata[7:0] & `FPSC_MSK_CMD;
                    next_seq = SEQ_CMD;
                end
                else if (wrCmd)
                begin
                    setAcc = 1'b1;
                    next_seq = SEQ_IDLE;
                end
            end
            SEQ_CMD:
            begin
                if (arrayWrite || wrCmd)
                begin
                    setAcc = 1'b1;
                    next_seq = SEQ_IDLE;
                end
            end
            default: next_seq = SEQ_IDLE;
        endcase
        if (wrStat && seq != SEQ_IDLE)
        begin
            next_seq = SEQ_IDLE;
            if (pwdata[`FPSC_BIT_CBEF] && seq == SEQ_CMD && !blocked)
            begin
                next_cbef = 1'b0;
                next_blank = 1'b0;
                next_launch = 1'b1;
            end
            else if (!pwdata[`FPSC_BIT_CBEF] || seq != SEQ_CMD)
            begin
                setAcc = 1'b1;
            end
        end
        if (stopReq && !ccf)
        begin
            setAcc = 1'b1;
        end
        // Engine fetch wins over a launch in the same cycle
        if (cmdTaken)
        begin
            next_cbef = 1'b1;
        end
        if (verifyDone && verifyBlank)
        begin
            next_blank = 1'b1;
        end
        // Hardware sets win over write-one clears
        next_viol = (viol && !(wrStat && pwdata[`FPSC_BIT_VIOL])) || setViol;
        next_access_error_flag = (access_error_flag && !(wrStat && pwdata[`FPSC_BIT_AERR])) || setAcc;
        next_fail = (fail && !(wrStat && specialMode && pwdata[`FPSC_BIT_FAIL])) ||
            (verifyDone && !verifyBlank && specialMode);
        next_ccf = next_cbef && !engineActive;
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data
    always_comb
    begin
        status = 8'h00;
        status[`FPSC_BIT_CBEF] = cbef;
        status[`FPSC_BIT_CCF] = ccf;
        status[`FPSC_BIT_VIOL] = viol;
        status[`FPSC_BIT_AERR] = access_error_flag;
        status[`FPSC_BIT_BLANK] = blank;
        if (specialMode)
        begin
            status[`FPSC_BIT_FAIL] = fail;
            status[`FPSC_BIT_DONE] = !engineActive;
        end
        case (idx)
            `FPSC_IDX_MODE: rdByte = {7'h00, specialMode};
            `FPSC_IDX_CONFIG: rdByte = cfgReg;
            `FPSC_IDX_PROT: rdByte = protConfig;
            `FPSC_IDX_STATUS: rdByte = status;
            `FPSC_IDX_CMD: rdByte = cmdCode;
            default: rdByte = 8'h00;
        endcase
        next_prdata = prdata;
        if (access && !ackd)
        begin
            next_prdata = (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rdByte};
        end
        next_ackd = access && !ackd;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ackd <= 1'b0;
            prdata <= 32'h0000_0000;
            seq <= SEQ_IDLE;
            cbef <= 1'b1;
            ccf <= 1'b1;
            viol <= 1'b0;
            access_error_flag <= 1'b0;
            blank <= 1'b0;
            fail <= 1'b0;
            cmdLaunch <= 1'b0;
            cmdCode <= `FPSC_RST_CMD;
            cfgReg <= `FPSC_RST_CONFIG;
            specialMode <= 1'b0;
            protConfig <= PROT_RESET;
        end
        else
        begin
            ackd <= next_ackd;
            prdata <= next_prdata;
            seq <= next_seq;
            cbef <= next_cbef;
            ccf <= next_ccf;
            viol <= next_viol;
            access_error_flag <= next_access_error_flag;
            blank <= next_blank;
            fail <= next_fail;
            cmdLaunch <= next_launch;
            cmdCode <= next_cmdCode;
            cfgReg <= next_config;
            specialMode <= next_specialMode;
            protConfig <= next_prot;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_launchReq;
        wrStat && pwdata[`FPSC_BIT_CBEF] && seq == SEQ_CMD && !blocked;
    endsequence

    sequence s_abortReq;
        wrStat && !pwdata[`FPSC_BIT_CBEF] && seq != SEQ_IDLE;
    endsequence

    a_prot_bad_ignored: assert property
        (wrProt && !protChk.allowed |=> $stable(protConfig))
        else $error("protection changed on a disallowed write");
    a_prot_full_locked: assert property
        (protChk.curIdx == 3'd3 |=> protChk.curIdx == 3'd3)
        else $error("scenario 3 was left");
    a_prot_open_any: assert property (wrProt && protChk.curIdx == 3'd7 |=>
        protConfig[`FPSC_BIT_OPEN] == $past(pwdata[`FPSC_BIT_OPEN]))
        else $error("scenario 7 refused a change");
    a_launch_pulse: assert property
        (s_launchReq |=> cmdLaunch && !cbef ##1 !cmdLaunch)
        else $error("launch not a single pulse with buffer full");
    a_abort_error: assert property
        (s_abortReq |=> access_error_flag && seq == SEQ_IDLE && !cmdLaunch)
        else $error("zero write mid-sequence did not abort");
    a_ccf_follows: assert property (!cbef |-> !ccf)
        else $error("complete set while buffer full");
    a_launch_block: assert property (blocked |=> !cmdLaunch)
        else $error("launch while an error flag was set");
    a_viol_sticky: assert property
        (viol && !(wrStat && pwdata[`FPSC_BIT_VIOL]) |=> viol)
        else $error("violation flag lost without a clear");
    a_error_sticky: assert property (access_error_flag && !wrStat |=> access_error_flag)
        else $error("access error lost without a clear");
    a_blank_cleared: assert property (cmdLaunch && !$past(verifyDone) |-> !blank)
        else $error("blank still set at launch");
    a_irq_complete: assert property (ccf && cfgReg[`FPSC_BIT_CCIRQ] |-> irqComplete)
        else $error("complete interrupt missing");
endmodule
`default_nettype wire

// file: rtl/fpsc_regs.svh
// Register indices, field positions, reset values and transition table
`ifndef FPSC_REGS_SVH
`define FPSC_REGS_SVH

// Word index; byte address is four times the index
`define FPSC_IDX_MODE 3'h1
`define FPSC_IDX_CONFIG 3'h3
`define FPSC_IDX_PROT 3'h4
`define FPSC_IDX_STATUS 3'h5
`define FPSC_IDX_CMD 3'h6

// command_status fields
`define FPSC_BIT_CBEF 7
`define FPSC_BIT_CCF 6
`define FPSC_BIT_VIOL 5
`define FPSC_BIT_AERR 4
`define FPSC_BIT_BLANK 2
`define FPSC_BIT_FAIL 1
`define FPSC_BIT_DONE 0

// flash_config fields
`define FPSC_BIT_BEIRQ 7
`define FPSC_BIT_CCIRQ 6

// protection_config fields
`define FPSC_BIT_OPEN 7
`define FPSC_BIT_HDIS 5
`define FPSC_BIT_LDIS 2
`define FPSC_MSK_HSIZE 8'h18
`define FPSC_MSK_LSIZE 8'h03

// Command code bits that exist; others read zero
`define FPSC_MSK_CMD 8'h65
`define FPSC_CMD_VERIFY 8'h05
`define FPSC_CMD_PROGRAM 8'h20
`define FPSC_CMD_SECTOR 8'h40
`define FPSC_CMD_MASS 8'h41

// Reset values
`define FPSC_RST_PROT 8'hFF
`define FPSC_RST_CONFIG 8'h00
`define FPSC_RST_CMD 8'h00

// Allowed targets per source scenario, bit n means scenario n
`define FPSC_ALLOW_0 8'h0F
`define FPSC_ALLOW_1 8'h0A
`define FPSC_ALLOW_2 8'h0C
`define FPSC_ALLOW_3 8'h08
`define FPSC_ALLOW_4 8'h18
`define FPSC_ALLOW_5 8'h3C
`define FPSC_ALLOW_6 8'h5A
`define FPSC_ALLOW_7 8'hFF

`endif

// file: rtl/fpsc_pkg.sv
// Types shared by the flash protection and status controller
package fpsc_pkg;
    typedef enum logic [2:0]
    {
        SEQ_IDLE = 3'b001,
        SEQ_ADDR = 3'b010,
        SEQ_CMD = 3'b100
    } fpsc_seq_t;
    typedef logic [2:0] fpsc_scen_t;
    typedef logic [7:0] fpsc_byte_t;
endpackage

// file: rtl/fpsc_prot_if.sv
// Scenario check signals between controller and transition checker
`timescale 1ns/1ps
`default_nettype none
interface fpsc_prot_if;
    import fpsc_pkg::*;
    fpsc_scen_t curIdx;
    fpsc_scen_t reqIdx;
    logic allowed;
    modport checker_side (input curIdx, input reqIdx, output allowed);
    modport user_side (output curIdx, output reqIdx, input allowed);
endinterface
`default_nettype wire

// file: rtl/fpsc_prot_check.sv
// Protection scenario transition checker
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_regs.svh"
module fpsc_prot_check
(
    fpsc_prot_if.checker_side chk
);
    import fpsc_pkg::*;
    fpsc_byte_t row;

    always_comb
    begin
        case (chk.curIdx)
            3'd0: row = `FPSC_ALLOW_0;
            3'd1: row = `FPSC_ALLOW_1;
            3'd2: row = `FPSC_ALLOW_2;
            3'd3: row = `FPSC_ALLOW_3;
            3'd4: row = `FPSC_ALLOW_4;
            3'd5: row = `FPSC_ALLOW_5;
            3'd6: row = `FPSC_ALLOW_6;
            3'd7: row = `FPSC_ALLOW_7;
            default: row = 8'h00;
        endcase
    end

    // Protection may only grow, except from the open scenario
    assign chk.allowed = row[chk.reqIdx];
endmodule
`default_nettype wire

// file: test/fpsc_core_model.sv
// Processor core model: APB master for the register port
`timescale 1ns/1ps
`default_nettype none
module fpsc_core_model
(
    input wire logic mclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [4:0] paddr,
    output var logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 5'h00;
        pwdata = 32'h0000_0000;
    end

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
        output logic [7:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale data would hide a late sample, so it is inverted
        pwdata <= ~{24'h00_0000, wd};
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the flash protection and status controller
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_regs.svh"
module testbench;
    import fpsc_pkg::*;
    localparam logic [7:0] ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
    localparam logic [7:0] CODES [4] = '{8'h05, 8'h20, 8'h40, 8'h41};
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic arrayWrite = 1'b0;
    logic arrayWriteProt = 1'b0;
    logic stopReq = 1'b0;
    logic cmdTaken = 1'b0;
    logic engineActive = 1'b0;
    logic verifyDone = 1'b0;
    logic verifyBlank = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, cmdLaunch, irqBufferEmpty, irqComplete;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata;
    fpsc_byte_t cmdCode, protConfig;
    logic [7:0] rv, code, w, expP;
    logic err, blank;
    int fails = 0;
    int checks = 0;
    int launches = 0;
    int n;

    fpsc_ctrl fpsc_ctrl_i (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arrayWrite(arrayWrite), .arrayWriteProt(arrayWriteProt),
        .stopReq(stopReq), .cmdTaken(cmdTaken), .engineActive(engineActive),
        .verifyDone(verifyDone), .verifyBlank(verifyBlank), .cmdLaunch(cmdLaunch),
        .cmdCode(cmdCode), .protConfig(protConfig), .irqBufferEmpty(irqBufferEmpty),
        .irqComplete(irqComplete));
    fpsc_core_model fpsc_core_model_i (.mclk(mclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    // Counted mid-cycle so a check at the next rising edge sees the update
    always @(negedge mclk)
        if (cmdLaunch === 1'b1)
            launches <= launches + 1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic doReset();
        resetn <= 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        fpsc_core_model_i.xfer(1'b1, idx, d, rv, err);
    endtask

    task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
        fpsc_core_model_i.xfer(1'b0, idx, 8'h00, rv, err);
        chk(rv, exp);
    endtask

    task automatic aw(input logic prot);
        arrayWriteProt <= prot;
        arrayWrite <= 1'b1;
        @(posedge mclk);
        arrayWrite <= 1'b0;
        arrayWriteProt <= 1'b0;
    endtask

    task automatic seq(input logic [7:0] c);
        aw(1'b0);
        wr(`FPSC_IDX_CMD, c);
        wr(`FPSC_IDX_STATUS, 8'h80);
    endtask

    // Engine fetches, reports busy, then finishes
    task automatic run(input logic ver, input logic bl, input logic [7:0] mid);
        cmdTaken <= 1'b1;
        engineActive <= 1'b1;
        @(posedge mclk);
        cmdTaken <= 1'b0;
        rdc(`FPSC_IDX_STATUS, mid);
        verifyDone <= ver;
        verifyBlank <= bl;
        @(posedge mclk);
        verifyDone <= 1'b0;
        engineActive <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    function automatic logic isValid(input logic [7:0] c);
        return c == 8'h05 || c == 8'h20 || c == 8'h40 || c == 8'h41;
    endfunction

    function automatic logic [7:0] scen(input logic [2:0] s);
        logic [7:0] v;
        v = 8'($urandom);
        v[7] = s[2];
        v[6] = 1'b1;
        v[5] = s[1];
        v[2] = s[0];
        return v;
    endfunction

    // Size fields only follow while the current range is disabled
    function automatic logic [7:0] protNext(input logic [7:0] cur, input logic [7:0] v);
        logic [7:0] nx;
        nx = v;
        if (!ALLOW[{cur[7], cur[5], cur[2]}][{v[7], v[5], v[2]}])
            return cur;
        if (!cur[5])
            nx[4:3] = cur[4:3];
        if (!cur[2])
            nx[1:0] = cur[1:0];
        return nx;
    endfunction

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hbf34_68ca));
        doReset();
        chk(protConfig, 8'hFF);
        rdc(`FPSC_IDX_PROT, 8'hFF);
        rdc(`FPSC_IDX_STATUS, 8'hC0);
        fpsc_core_model_i.xfer(1'b0, 3'h7, 8'h00, rv, err);
        chk({7'h00, err}, 8'h01);
        chk(rv, 8'h00);
        wr(`FPSC_IDX_STATUS, 8'h7F);
        rdc(`FPSC_IDX_STATUS, 8'hC0);
        wr(`FPSC_IDX_CONFIG, 8'hC0);
        chk({6'h00, irqBufferEmpty, irqComplete}, 8'h03);
        for (int i = 0; i < 12; i++)
        begin
            code = (i < 4) ? CODES[i] : 8'($urandom);
            while (i >= 4 && isValid(code & 8'h65))
                code = 8'($urandom);
            n = launches;
            if (i < 4)
            begin
                blank = 1'($urandom);
                seq(code);
                chk(8'(launches - n), 8'h01);
                chk(cmdCode, code);
                chk({6'h00, irqBufferEmpty, irqComplete}, 8'h00);
                rdc(`FPSC_IDX_STATUS, 8'h00);
                run(code == 8'h05, blank, 8'h80);
                rdc(`FPSC_IDX_STATUS, {5'h18, blank && code == 8'h05, 2'h0});
            end
            else
            begin
                aw(1'b0);
                wr(`FPSC_IDX_CMD, code);
                rdc(`FPSC_IDX_STATUS, 8'hD0);
                wr(`FPSC_IDX_STATUS, 8'h10);
                rdc(`FPSC_IDX_STATUS, 8'hC0);
            end
        end
        seq(8'h20);
        stopReq <= 1'b1;
        @(posedge mclk);
        stopReq <= 1'b0;
        run(1'b0, 1'b0, 8'h90);
        wr(`FPSC_IDX_STATUS, 8'h10);
        aw(1'b1);
        wr(`FPSC_IDX_STATUS, 8'h00);
        rdc(`FPSC_IDX_STATUS, 8'hE0);
        n = launches;
        seq(8'h40);
        chk(8'(launches - n), 8'h00);
        wr(`FPSC_IDX_STATUS, 8'h30);
        rdc(`FPSC_IDX_STATUS, 8'hC0);
        aw(1'b0);
        wr(`FPSC_IDX_STATUS, 8'h00);
        rdc(`FPSC_IDX_STATUS, 8'hD0);
        wr(`FPSC_IDX_STATUS, 8'h10);
        wr(`FPSC_IDX_MODE, 8'h01);
        rdc(`FPSC_IDX_STATUS, 8'hC1);
        seq(8'h05);
        run(1'b1, 1'b0, 8'h80);
        wr(`FPSC_IDX_STATUS, 8'h00);
        rdc(`FPSC_IDX_STATUS, 8'hC3);
        n = launches;
        seq(8'h20);
        chk(8'(launches - n), 8'h00);
        wr(`FPSC_IDX_STATUS, 8'h32);
        rdc(`FPSC_IDX_STATUS, 8'hC1);
        n = launches;
        seq(8'h20);
        chk(8'(launches - n), 8'h01);
        run(1'b0, 1'b0, 8'h80);
        wr(`FPSC_IDX_MODE, 8'h00);
        rdc(`FPSC_IDX_STATUS, 8'hC0);
        for (int f = 0; f < 8; f++)
            for (int t = 0; t < 8; t++)
            begin
                doReset();
                w = scen(3'(f));
                wr(`FPSC_IDX_PROT, w);
                expP = protNext(8'hFF, w);
                rdc(`FPSC_IDX_PROT, expP);
                w = scen(3'(t));
                wr(`FPSC_IDX_PROT, w);
                expP = protNext(expP, w);
                rdc(`FPSC_IDX_PROT, expP);
                chk(protConfig, expP);
            end
        end_of_test();
    end
endmodule
`default_nettype wire
